// *** hpdp_board.sv ***
// Board end of the parallel host link
`timescale 1ns/1ns
module hpdp_board #(
  parameter logic [hpdp_pkg::SEL_WIDTH-1:0] SLAVE_ADDR = 3'h0
) (
  input  wire logic                            clock,
  input  wire logic                            arst_n,
  input  wire logic                            clk_en,
  hpdp_link_if.board                           link,
  // Board-to-host bytes, buffered
  input  wire logic [hpdp_pkg::DATA_WIDTH-1:0] tx_data,
  input  wire logic                            tx_valid,
  output logic                                 tx_ready,
  // Host-to-board bytes
  output logic      [hpdp_pkg::DATA_WIDTH-1:0] rx_data,
  output logic                                 rx_valid,
  output logic                                 soft_reset_out,
  output logic                                 hard_reset_out,
  output logic                                 debug_enable,
  output logic                                 host_powered
);
  localparam int DW = hpdp_pkg::DATA_WIDTH;
  localparam int SN = hpdp_pkg::SYNC_STAGES;
  localparam int NIN = 7 + hpdp_pkg::SEL_WIDTH + hpdp_pkg::VCC_LINES + DW;

  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic [NIN-1:0] s3_reg;
  logic [NIN-1:0] clean_reg;
  logic [hpdp_pkg::SEL_WIDTH-1:0] sel_c;
  logic [hpdp_pkg::VCC_LINES-1:0] vcc_c;
  logic [DW-1:0]  pd_c;
  logic           sreset_c;
  logic           hreset_c;
  logic           present_n_c;
  logic           hreq_c;
  logic           hack_c;
  logic           selected;
  logic           link_clear;
  logic           connected;
  hpdp_pkg::hpdp_hs_type rx_reg;
  hpdp_pkg::hpdp_hs_type tx_reg;
  logic [DW-1:0]  f_data;
  logic           f_valid;
  logic           f_ready;
  logic [DW-1:0]  out_reg;

  // Gather all cable inputs for synchronising
  assign raw = {link.select, link.host_vcc, link.parallel_data, link.host_soft_reset,
                link.host_hard_reset, link.host_present_n, link.host_req,
                link.host_write_ack, 2'h0};

  // Three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      clean_reg <= {{(NIN-5){1'b0}}, 5'h10};   // Host absent, ack low until seen
    end else if (clk_en) begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NIN; i++) begin
        if (s2_reg[i] == s3_reg[i]) clean_reg[i] <= s3_reg[i];
      end
    end
  end

  assign {sel_c, vcc_c, pd_c, sreset_c, hreset_c, present_n_c, hreq_c, hack_c} =
         clean_reg[NIN-1:2];
  assign host_powered = &vcc_c;
  assign connected    = !present_n_c && host_powered;
  assign debug_enable = connected;
  assign selected     = connected && (sel_c == SLAVE_ADDR);
  assign link_clear   = selected && sreset_c && hreset_c;

  // Reset requests to the processor and board
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_out <= 1'b0;
      hard_reset_out <= 1'b0;
    end else if (clk_en) begin
      soft_reset_out <= selected && sreset_c && !hreset_c;
      hard_reset_out <= selected && hreset_c && !sreset_c;
    end
  end

  // Host-to-board handshake: capture byte, ack, wait for request to drop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_reg   <= hpdp_pkg::HS_IDLE;
      rx_data  <= '0;
      rx_valid <= 1'b0;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      if (link_clear || !selected) begin
        rx_reg <= hpdp_pkg::HS_IDLE;
      end else begin
        unique case (rx_reg)
          // Wait out an own send so the shared bus carries host data
          hpdp_pkg::HS_IDLE: if (hreq_c && !hack_c &&
                                 tx_reg == hpdp_pkg::HS_IDLE) begin
            rx_data  <= pd_c;
            rx_valid <= 1'b1;
            rx_reg   <= hpdp_pkg::HS_DONE;
          end
          hpdp_pkg::HS_DONE: if (!hreq_c) rx_reg <= hpdp_pkg::HS_IDLE;
          default: rx_reg <= hpdp_pkg::HS_IDLE;
        endcase
      end
    end
  end
  assign link.board_ack = selected && (rx_reg == hpdp_pkg::HS_DONE);

  // Outgoing byte buffer
  hpdp_fifo #(.WIDTH(DW), .DEPTH(hpdp_pkg::FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .flush     (link_clear),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );
  assign f_ready = clk_en && selected && (tx_reg == hpdp_pkg::HS_IDLE) && !hack_c && !hreq_c;

  // Board-to-host handshake: drive byte, request, wait for ack, release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_reg  <= hpdp_pkg::HS_IDLE;
      out_reg <= '0;
    end else if (clk_en) begin
      if (link_clear || !selected) begin
        tx_reg <= hpdp_pkg::HS_IDLE;
      end else begin
        unique case (tx_reg)
          hpdp_pkg::HS_IDLE: if (f_valid && f_ready) begin
            out_reg <= f_data;
            tx_reg  <= hpdp_pkg::HS_REQ;
          end
          hpdp_pkg::HS_REQ:  if (hack_c) tx_reg <= hpdp_pkg::HS_DONE;
          hpdp_pkg::HS_DONE: if (!hack_c) tx_reg <= hpdp_pkg::HS_IDLE;
          default: tx_reg <= hpdp_pkg::HS_IDLE;
        endcase
      end
    end
  end
  assign link.board_req      = selected && (tx_reg == hpdp_pkg::HS_REQ);
  assign link.board_data_out = out_reg;
  assign link.board_data_oe  = selected && (tx_reg == hpdp_pkg::HS_REQ);
endmodule // hpdp_board

// *** hpdp_pkg.sv ***
// Package of constants and types shared by both ends of the parallel host link
// Overview of operation
// - Board answers only when select equals address
// - Selected soft-reset request holds processor soft reset for as long as it lasts
// - Host holds presence line low while connected
// - No host: debug controller disabled, outputs released
// - Selected hard-reset request holds board hard reset for as long as it lasts
// - Both reset lines together clear link logic
// - Host starts each write by raising request
// - Board acknowledges a detected host request
// - Board starts each write by raising request
// - Host acknowledges each board request
// - Board decides host power from sense lines
// - One eight-bit two-way data bus, both directions
package hpdp_pkg;
  localparam int          DATA_WIDTH   = 8;
  localparam int          SEL_WIDTH    = 3;
  localparam int          VCC_LINES    = 3;
  localparam int          FIFO_DEPTH   = 8;
  localparam int          SYNC_STAGES  = 3;
  localparam logic [2:0]  SYNC_IDLE    = 3'h0;
  // States of a four-phase handshake end
  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_REQ  = 3'h2,
    HS_DONE = 3'h4
  } hpdp_hs_type;
endpackage

// *** hpdp_link_if.sv ***
// Interface carrying the cable between host adapter and board
`timescale 1ns/1ns
interface hpdp_link_if;
  logic [hpdp_pkg::SEL_WIDTH-1:0]  select;
  logic                            host_soft_reset;
  logic                            host_hard_reset;
  logic                            host_present_n;
  logic [hpdp_pkg::VCC_LINES-1:0]  host_vcc;
  logic                            host_req;
  logic                            board_ack;
  logic                            board_req;
  logic                            host_write_ack;
  logic [hpdp_pkg::DATA_WIDTH-1:0] host_data_out;
  logic                            host_data_oe;
  logic [hpdp_pkg::DATA_WIDTH-1:0] board_data_out;
  logic                            board_data_oe;
  logic [hpdp_pkg::DATA_WIDTH-1:0] parallel_data;
  // Resolved bus level: board drives when it enables, else host when it enables, else pulled high
  assign parallel_data = board_data_oe ? board_data_out :
                         host_data_oe  ? host_data_out  : {hpdp_pkg::DATA_WIDTH{1'b1}};
  modport board (
    input  select, host_soft_reset, host_hard_reset, host_present_n, host_vcc,
    input  host_req, host_write_ack, parallel_data,
    output board_ack, board_req, board_data_out, board_data_oe
  );
  modport host (
    output select, host_soft_reset, host_hard_reset, host_present_n, host_vcc,
    output host_req, host_write_ack, host_data_out, host_data_oe,
    input  board_ack, board_req, parallel_data
  );
endinterface // hpdp_link_if

// *** hpdp_fifo.sv ***
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
module hpdp_fifo #(
  parameter int WIDTH = hpdp_pkg::DATA_WIDTH,
  parameter int DEPTH = hpdp_pkg::FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Flags straight from the fill count
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage writes
  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wr_reg    <= '0;
        rd_reg    <= '0;
        count_reg <= '0;
      end else begin
        if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
        if (pop)  rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
        count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule // hpdp_fifo

// *** hpdp_host.sv ***
// Host adapter end of the parallel host link
`timescale 1ns/1ns
module hpdp_host (
  input  wire logic                                 clock,
  input  wire logic                                 arst_n,
  input  wire logic                                 clk_en,
  hpdp_link_if.host                                 link,
  input  wire logic [hpdp_pkg::SEL_WIDTH-1:0]       target,
  input  wire logic                                 soft_reset_cmd,
  input  wire logic                                 hard_reset_cmd,
  input  wire logic [hpdp_pkg::DATA_WIDTH-1:0]      wr_data,
  input  wire logic                                 wr_valid,
  output logic                                      wr_ready,
  output logic      [hpdp_pkg::DATA_WIDTH-1:0]      rd_data,
  output logic                                      rd_valid
);
  logic [2:0] ack_s_reg;
  logic [2:0] req_s_reg;
  logic       ack_c_reg;
  logic       req_c_reg;
  hpdp_pkg::hpdp_hs_type w_reg;
  hpdp_pkg::hpdp_hs_type r_reg;
  logic [hpdp_pkg::DATA_WIDTH-1:0] d_reg;

  assign link.select          = target;
  assign link.host_soft_reset = soft_reset_cmd;
  assign link.host_hard_reset = hard_reset_cmd;
  assign link.host_present_n  = 1'b0;
  assign link.host_vcc        = '1;
  assign link.host_req        = (w_reg == hpdp_pkg::HS_REQ);
  assign link.host_data_out   = d_reg;
  assign link.host_data_oe    = (w_reg != hpdp_pkg::HS_IDLE);
  assign link.host_write_ack  = (r_reg == hpdp_pkg::HS_DONE);
  assign wr_ready = clk_en && (w_reg == hpdp_pkg::HS_IDLE) && !ack_c_reg;

  // Synchronise board ack and request, agreeing second and third stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_s_reg <= hpdp_pkg::SYNC_IDLE;
      req_s_reg <= hpdp_pkg::SYNC_IDLE;
      ack_c_reg <= 1'b0;
      req_c_reg <= 1'b0;
    end else if (clk_en) begin
      ack_s_reg <= {ack_s_reg[1:0], link.board_ack};
      req_s_reg <= {req_s_reg[1:0], link.board_req};
      if (ack_s_reg[1] == ack_s_reg[2]) ack_c_reg <= ack_s_reg[2];
      if (req_s_reg[1] == req_s_reg[2]) req_c_reg <= req_s_reg[2];
    end
  end

  // Write handshake: data and request together, hold until ack, drop, wait ack low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      w_reg <= hpdp_pkg::HS_IDLE;
      d_reg <= '0;
    end else if (clk_en) begin
      unique case (w_reg)
        hpdp_pkg::HS_IDLE: if (wr_valid && wr_ready) begin
          d_reg <= wr_data;
          w_reg <= hpdp_pkg::HS_REQ;
        end
        hpdp_pkg::HS_REQ:  if (ack_c_reg) w_reg <= hpdp_pkg::HS_DONE;
        hpdp_pkg::HS_DONE: if (!ack_c_reg) w_reg <= hpdp_pkg::HS_IDLE;
        default: w_reg <= hpdp_pkg::HS_IDLE;
      endcase
    end
  end

  // Read handshake: take byte on board request, ack until request drops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r_reg    <= hpdp_pkg::HS_IDLE;
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      unique case (r_reg)
        hpdp_pkg::HS_IDLE: if (req_c_reg) begin
          rd_data  <= link.parallel_data;
          rd_valid <= 1'b1;
          r_reg    <= hpdp_pkg::HS_DONE;
        end
        hpdp_pkg::HS_DONE: if (!req_c_reg) r_reg <= hpdp_pkg::HS_IDLE;
        default: r_reg <= hpdp_pkg::HS_IDLE;
      endcase
    end
  end
endmodule // hpdp_host

// *** hpdp_link_assertions.sv ***
// Concurrent checks on the cable joining the host end and the board end
`timescale 1ns/1ns
module hpdp_link_assertions (
  input wire logic                            clock,
  input wire logic                            arst_n,
  input wire logic                            host_soft_reset,
  input wire logic                            host_hard_reset,
  input wire logic                            host_req,
  input wire logic                            board_ack,
  input wire logic                            board_req,
  input wire logic                            host_write_ack,
  input wire logic                            board_data_oe,
  input wire logic [hpdp_pkg::DATA_WIDTH-1:0] board_data_out
);
  // Combined reset clears the link, so checks pause while it is set
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n || (host_soft_reset && host_hard_reset));
  ack_needs_req_a: assert property ($rose(board_ack) |-> host_req)
    else $error("board ack rose without host request");
  ack_answer_a: assert property ($rose(host_req) |-> ##[1:32] board_ack)
    else $error("board ack missing after host request");
  req_hold_a: assert property (host_req && !board_ack |=> host_req)
    else $error("host request dropped before ack");
  ack_hold_a: assert property (board_ack && host_req |=> board_ack)
    else $error("board ack dropped while request high");
  ack_release_a: assert property ($fell(host_req) |-> ##[1:16] !board_ack)
    else $error("board ack not released");
  board_hold_a: assert property (board_req && !host_write_ack |=> board_req)
    else $error("board request dropped before ack");
  host_answer_a: assert property ($rose(board_req) |-> ##[1:16] host_write_ack)
    else $error("host ack missing after board request");
  board_start_a: assert property ($rose(board_req) |-> !host_write_ack)
    else $error("board request raised while host ack high");
  board_oe_own_a: assert property (board_data_oe |-> board_req)
    else $error("board drives data outside its write");
  data_stable_a: assert property (board_data_oe && $past(board_data_oe)
    |-> $stable(board_data_out))
    else $error("board data changed during its write");
endmodule // hpdp_link_assertions

// *** hpdp_test.sv ***
// Self-checking bench: host end and first board end joined over the cable, second board end on a bench-driven cable
`timescale 1ns/1ns
module hpdp_test;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic       clk_en = 1'b1;
  logic [2:0] target = 3'h2;
  logic       soft_cmd = 1'b0, hard_cmd = 1'b0, wr_valid = 1'b0, tx_valid = 1'b0;
  logic [7:0] wr_data = 8'h00, tx_data = 8'h00, rd_data, rx_data, rx2_data, rx2_last;
  logic       wr_ready, rd_valid, tx_ready, rx_valid, rx2_valid;
  logic       soft_out, hard_out, dbg_en, powered, dbg2, pwr2;
  logic [7:0] hq[$], bq[$];
  int         error_cnt = 0, n_compared = 0, rx2_cnt = 0, seed = 77745;
  bit         stall = 1'b0;
  hpdp_link_if link ();
  hpdp_link_if link2 ();
  hpdp_host hpdp_host_i (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .link(link),
    .target(target), .soft_reset_cmd(soft_cmd), .hard_reset_cmd(hard_cmd), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid));
  hpdp_board #(.SLAVE_ADDR(3'h2)) hpdp_board_i (.clock(clock), .arst_n(arst_n),
    .clk_en(clk_en), .link(link), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .soft_reset_out(soft_out),
    .hard_reset_out(hard_out), .debug_enable(dbg_en), .host_powered(powered));
  // Second board driven straight by the bench to play a faulty or absent host
  hpdp_board #(.SLAVE_ADDR(3'h5)) hpdp_board_i2 (.clock(clock), .arst_n(arst_n),
    .clk_en(clk_en), .link(link2), .tx_data(8'h00), .tx_valid(1'b0), .tx_ready(),
    .rx_data(rx2_data), .rx_valid(rx2_valid), .soft_reset_out(), .hard_reset_out(),
    .debug_enable(dbg2), .host_powered(pwr2));
  hpdp_link_assertions hpdp_link_assertions_i (.clock(clock), .arst_n(arst_n),
    .host_soft_reset(link.host_soft_reset), .host_hard_reset(link.host_hard_reset),
    .host_req(link.host_req), .board_ack(link.board_ack), .board_req(link.board_req),
    .host_write_ack(link.host_write_ack), .board_data_oe(link.board_data_oe),
    .board_data_out(link.board_data_out));
  // Clock generation
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Offers one byte on the host side (dir 0) or board side (dir 1)
  task automatic send(input bit dir, input logic [7:0] d, output bit waited);
    int i;
    @(negedge clock);
    if (dir) {tx_data, tx_valid} = {d, 1'b1};
    else {wr_data, wr_valid} = {d, 1'b1};
    // Ready is looked at while settled; the byte moves at the next rising edge
    for (i = 0; i < 400; i++) begin
      if ((dir ? tx_ready : wr_ready) === 1'b1) break;
      @(negedge clock);
    end
    @(posedge clock);
    chk(i < 400, "byte never accepted");
    waited = (i > 0);
    if (dir) bq.push_back(d);
    else hq.push_back(d);
    @(negedge clock);
    if (dir) tx_valid = 1'b0;
    else wr_valid = 1'b0;
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 3000 && (hq.size() + bq.size()) > 0; i++) @(negedge clock);
    chk(i < 3000, "link did not drain");
  endtask
  // First-link receivers compare each delivered byte with the oldest one sent; second board's bytes are counted and the last one kept
  always @(negedge clock) begin
    if (rx_valid === 1'b1) begin
      chk(hq.size() > 0 && rx_data === hq[0], "host to board byte");
      if (hq.size() > 0) void'(hq.pop_front());
    end
    if (rd_valid === 1'b1) begin
      chk(bq.size() > 0 && rd_data === bq[0], "board to host byte");
      if (bq.size() > 0) void'(bq.pop_front());
    end
    if (rx2_valid === 1'b1) begin
      rx2_cnt++;
      rx2_last = rx2_data;
    end
  end
  // Main sequence
  initial begin
    int i;
    bit w;
    link2.select = 3'h5;
    {link2.host_soft_reset, link2.host_hard_reset, link2.host_req} = 3'h0;
    {link2.host_write_ack, link2.host_data_oe, link2.host_present_n} = 3'h1;
    link2.host_vcc = 3'h7;
    link2.host_data_out = 8'h00;
    repeat (12) @(negedge clock);
    arst_n = 1'b1;
    repeat (8) @(negedge clock);
    chk(dbg_en === 1'b1 && powered === 1'b1, "host present");
    chk(dbg2 === 1'b0 && link2.board_data_oe === 1'b0, "absent host");
    fork
      begin
        send(1'b0, 8'hFF, w);
        for (int k = 0; k < 15; k++) send(1'b0, 8'($random(seed)), w);
      end
      begin
        send(1'b1, 8'h00, w);
        for (int k = 0; k < 13; k++) begin
          send(1'b1, 8'($random(seed)), w);
          stall |= w;
        end
      end
    join
    drain();
    chk(stall, "board fifo never refused");
    for (i = 1; i < 4; i++) begin
      {hard_cmd, soft_cmd} = i[1:0];
      repeat (12) @(negedge clock);
      chk(soft_out === (i == 1) && hard_out === (i == 2), "reset outputs");
      {hard_cmd, soft_cmd} = 2'h0;
      repeat (12) @(negedge clock);
      chk(soft_out === 1'b0 && hard_out === 1'b0, "reset released");
    end
    send(1'b0, 8'($random(seed)), w);
    send(1'b1, 8'($random(seed)), w);
    drain();
    {link2.host_present_n, link2.host_vcc} = 4'h3;
    repeat (8) @(negedge clock);
    chk(pwr2 === 1'b0 && dbg2 === 1'b0, "partial host power");
    link2.host_vcc = 3'h7;
    repeat (8) @(negedge clock);
    chk(pwr2 === 1'b1 && dbg2 === 1'b1, "powered host");
    {link2.select, link2.host_data_out, link2.host_data_oe, link2.host_req} = 13'h0973;
    repeat (16) @(negedge clock);
    chk(link2.board_ack === 1'b0 && rx2_cnt == 0, "other slave address");
    link2.select = 3'h5;
    repeat (16) @(negedge clock);
    chk(link2.board_ack === 1'b1 && rx2_cnt == 1 && rx2_last === 8'h5C, "own address");
    {link2.host_req, link2.host_data_oe} = 2'h0;
    repeat (16) @(negedge clock);
    chk(link2.board_ack === 1'b0, "ack released");
    tally_and_finish();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
endmodule // hpdp_test
